// File: design/ibsc_pkg.sv
// Shared constants and types for the boot, reprogramming and code protection control block.
package ibsc_pkg;

  // Register indices; the byte address of each is four times its index.
  localparam logic [7:0] CTRL_IDX = 8'hBF;
  localparam logic [7:0] UNLOCK_IDX = 8'hC0;
  localparam logic [7:0] STATUS_IDX = 8'hC1;
  localparam logic [7:0] SEC_IDX = 8'hC2;

  // Field positions in the programming control register.
  localparam int CTRL_REBOOT_BIT = 7;
  localparam int CTRL_AUX_BIT = 4;
  localparam int CTRL_SEL_BIT = 1;
  localparam int CTRL_PE_BIT = 0;

  // Field positions in the security register; an erased bit reads 1.
  localparam int SEC_LOCK_BIT = 0;
  localparam int SEC_CODE_READ_BIT = 1;
  localparam int SEC_ENC_BIT = 2;
  localparam int SEC_OSC_BIT = 7;
  localparam logic [7:0] SEC_ERASED = 8'hFF;

  // Field positions in the status register.
  localparam int STAT_FORCED_BIT = 0;
  localparam int STAT_ISP_BIT = 1;
  localparam int STAT_OPEN_BIT = 2;
  localparam int STAT_READY_BIT = 3;

  // Write unlock sequence values.
  localparam logic [7:0] UNLOCK_KEY1 = 8'h87;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h59;

  // Clock edges to wait after reset before the strap pins are caught.
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // AXI4-Lite response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ULK_CLOSED, ULK_HALF, ULK_OPEN} ibsc_unlock_type;

endpackage

// File: design/ibsc_isp_boot_security.sv
// Boot source, in-system programming control and code protection with an AXI4-Lite slave.
`timescale 1ns/100ps

// Notes on behaviour
// - Reboot when bits 7, 1, 0 written one
// - Bit 7 reads one in forced loader boot
// - Bit 4 enables the auxiliary RAM
// - Bit 1 picks loader bank and reprogram target
// - Program enable plus idle wake enters programming
// - Program enable clear refuses all flash operations
// - Default boot is the application bank
// - Straps low at reset force loader boot
// - Security bits only fall; erase-all restores them
// - Security register hidden during programming mode
// - Inhibit zero: external code reads external only
// - Internal code reads internal and external freely
// - Inhibit one places no code read limit
// - Encryption enabled encodes port zero data
// - Encryption cleared only by whole-chip erase
// - Oscillator bit zero halves amplifier gain
// - Entering loader bank clears program counter
module ibsc_isp_boot_security
  import ibsc_pkg::*;
#(
  parameter logic [7:0] ENC_KEY = 8'h5A,
  parameter logic [7:0] SEC_INIT = SEC_ERASED,
  parameter logic [1:0] SETTLE = STRAP_SETTLE
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic strap_p27,
  input wire logic strap_p26,
  input wire logic strap_p43,
  input wire logic cpu_idle,
  input wire logic wake_irq,
  input wire logic chip_erase_req,
  input wire logic flash_op_req,
  input wire logic code_read_from_internal,
  input wire logic code_read_target_internal,
  input wire logic [7:0] p0_data_in,
  output logic cpu_reset_out,
  output logic pc_clear,
  output logic exec_from_loader,
  output logic isp_mode,
  output logic flash_op_grant,
  output logic loader_in_small_bank,
  output logic reprog_target_large,
  output logic aux_ram_enable,
  output logic code_read_use_internal,
  output logic [7:0] p0_data_out,
  output logic osc_half_gain
);

  // A zero settle count would catch the straps before the synchroniser holds them.
  if (SETTLE == 2'h0)
  begin : g_chk
    $error("SETTLE must be at least one");
  end

  // Word index of a byte address.
  function automatic logic [7:0] reg_index(input logic [9:0] a);
    return a[9:2];
  endfunction

  // Aligned access to one of the four registers.
  function automatic logic is_mapped(input logic [9:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[1:0] == 2'h0) && (i == CTRL_IDX || i == UNLOCK_IDX || i == STATUS_IDX ||
      i == SEC_IDX);
  endfunction

  // Port 0 scrambler: a rotate then a key mask, cheap and reversible.
  function automatic logic [7:0] encode(input logic [7:0] d);
    return {d[2:0], d[7:3]} ^ ENC_KEY;
  endfunction

  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next, w_strb0_reg, w_strb0_next;
  logic [9:0] aw_addr_reg, aw_addr_next;
  logic [7:0] w_data_reg, w_data_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  ibsc_unlock_type ulk_reg, ulk_next;
  logic aux_reg, aux_next, sel_reg, sel_next, pe_reg, pe_next;
  logic soft_rst_reg, soft_rst_next, isp_reg, isp_next, pc_clear_reg, pc_clear_next;
  logic forced_reg, forced_next, captured_reg, captured_next;
  logic [1:0] cap_cnt_reg, cap_cnt_next;
  logic [2:0] strap_s1_reg, strap_s2_reg;
  logic [7:0] sec_reg, sec_next, p0_out_reg, p0_out_next;
  logic do_write, wr_ok, code_read_free, enter_isp;
  logic [7:0] wr_idx, wr_byte, ctrl_view;

  // The write is performed once address and data are both held and no response is pending.
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_ok = do_write && w_strb0_reg && is_mapped(aw_addr_reg);
  assign wr_idx = reg_index(aw_addr_reg);
  assign wr_byte = w_data_reg;
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Readback of the control register; reserved bits are constant zero.
  assign ctrl_view = {forced_reg, 2'h0, aux_reg, 2'h0, sel_reg, pe_reg};

  // Bus channel state; a lane-0 strobe is needed since all registers are one byte wide.
  always_comb
  begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb0_next = w_strb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata[7:0];
      w_strb0_next = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_next = 32'h0000_0000;
      if (is_mapped(s_axi_araddr))
      begin
        case (reg_index(s_axi_araddr))
          CTRL_IDX: rdata_next[7:0] = ctrl_view;
          UNLOCK_IDX: rdata_next[7:0] = 8'h00;
          STATUS_IDX: rdata_next[3:0] = {captured_reg, ulk_reg == ULK_OPEN, isp_reg,
            forced_reg};
          SEC_IDX: rdata_next[7:0] = isp_reg ? 8'h00 : sec_reg;
          default: rdata_next = 32'h0000_0000;
        endcase
      end
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
  end

  // Bus channel registers.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 10'h000;
      w_hold_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else
    begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb0_reg <= w_strb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Strap pins are asynchronous; only the second stage is looked at.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_s1_reg <= 3'h7;
      strap_s2_reg <= 3'h7;
    end
    else
    begin
      strap_s1_reg <= {strap_p27, strap_p26, strap_p43};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Isp mode is entered on the interrupt wake from idle with programming enabled.
  assign enter_isp = pe_reg && cpu_idle && wake_irq && !isp_reg && captured_reg;

  // Core control state: unlock, control bits, boot source, security and port 0 path.
  always_comb
  begin
    ulk_next = ulk_reg;
    aux_next = aux_reg;
    sel_next = sel_reg;
    pe_next = pe_reg;
    soft_rst_next = 1'b0;
    isp_next = isp_reg;
    pc_clear_next = 1'b0;
    forced_next = forced_reg;
    captured_next = captured_reg;
    cap_cnt_next = cap_cnt_reg;
    sec_next = sec_reg;
    // Straps are caught a few edges after reset so the synchroniser holds the pin levels.
    if (!captured_reg)
    begin
      if (cap_cnt_reg == SETTLE)
      begin
        forced_next = (!strap_s2_reg[2] && !strap_s2_reg[1]) || !strap_s2_reg[0];
        captured_next = 1'b1;
      end
      else
      begin
        cap_cnt_next = cap_cnt_reg + 2'h1;
      end
    end
    if (wr_ok && wr_idx == UNLOCK_IDX)
    begin
      if (wr_byte == UNLOCK_KEY1)
      begin
        ulk_next = (ulk_reg == ULK_OPEN) ? ULK_OPEN : ULK_HALF;
      end
      else if (wr_byte == UNLOCK_KEY2 && ulk_reg != ULK_CLOSED)
      begin
        ulk_next = ULK_OPEN;
      end
      else
      begin
        ulk_next = ULK_CLOSED;
      end
    end
    // Control writes only land while unlocked; bits 3, 2 and the reserved bits are dropped.
    if (wr_ok && wr_idx == CTRL_IDX && ulk_reg == ULK_OPEN)
    begin
      aux_next = wr_byte[CTRL_AUX_BIT];
      sel_next = wr_byte[CTRL_SEL_BIT];
      pe_next = wr_byte[CTRL_PE_BIT];
      if (!wr_byte[CTRL_PE_BIT])
      begin
        isp_next = 1'b0;
      end
      soft_rst_next = wr_byte[CTRL_REBOOT_BIT] && wr_byte[CTRL_SEL_BIT] &&
        wr_byte[CTRL_PE_BIT];
    end
    // Isp entry follows the control write, so entry wins over a clear in the same cycle.
    if (enter_isp)
    begin
      isp_next = 1'b1;
      pc_clear_next = !forced_reg;
    end
    // Security bits can only be programmed downward and are invisible in isp mode.
    if (wr_ok && wr_idx == SEC_IDX && !isp_reg)
    begin
      sec_next = sec_reg & wr_byte;
    end
    // Whole-chip erase is the only path that raises security bits again.
    if (chip_erase_req && !isp_reg)
    begin
      sec_next = SEC_ERASED;
    end
    // A soft reboot returns the unlock, control, isp and strap capture state to power-on state; security and bus state are kept.
    if (soft_rst_reg)
    begin
      ulk_next = ULK_CLOSED;
      aux_next = 1'b0;
      sel_next = 1'b0;
      pe_next = 1'b0;
      isp_next = 1'b0;
      pc_clear_next = 1'b0;
      forced_next = 1'b0;
      captured_next = 1'b0;
      cap_cnt_next = 2'h0;
    end
    p0_out_next = sec_reg[SEC_ENC_BIT] ? p0_data_in : encode(p0_data_in);
  end

  // Core control registers; the security byte resets to its stored image.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ulk_reg <= ULK_CLOSED;
      aux_reg <= 1'b0;
      sel_reg <= 1'b0;
      pe_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      isp_reg <= 1'b0;
      pc_clear_reg <= 1'b0;
      forced_reg <= 1'b0;
      captured_reg <= 1'b0;
      cap_cnt_reg <= 2'h0;
      sec_reg <= SEC_INIT;
      p0_out_reg <= 8'h00;
    end
    else
    begin
      ulk_reg <= ulk_next;
      aux_reg <= aux_next;
      sel_reg <= sel_next;
      pe_reg <= pe_next;
      soft_rst_reg <= soft_rst_next;
      isp_reg <= isp_next;
      pc_clear_reg <= pc_clear_next;
      forced_reg <= forced_next;
      captured_reg <= captured_next;
      cap_cnt_reg <= cap_cnt_next;
      sec_reg <= sec_next;
      p0_out_reg <= p0_out_next;
    end
  end

  // The CPU is held until the straps are caught, and again on a soft reboot until the straps are caught anew.
  assign cpu_reset_out = !captured_reg || soft_rst_reg;
  assign pc_clear = pc_clear_reg;
  assign exec_from_loader = forced_reg || isp_reg;
  assign isp_mode = isp_reg;
  assign flash_op_grant = flash_op_req && isp_reg && pe_reg && cpu_idle;
  assign loader_in_small_bank = sel_reg;
  assign reprog_target_large = sel_reg;
  assign aux_ram_enable = aux_reg;
  // Internal code, or an inhibit bit left at one, may read the internal flash.
  assign code_read_free = code_read_from_internal || sec_reg[SEC_CODE_READ_BIT];
  assign code_read_use_internal = code_read_target_internal && code_read_free;
  assign p0_data_out = p0_out_reg;
  assign osc_half_gain = !sec_reg[SEC_OSC_BIT];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_reboot_write;
    wr_ok && wr_idx == CTRL_IDX && ulk_reg == ULK_OPEN && wr_byte[7] && wr_byte[1] && wr_byte[0];
  endsequence

  sequence s_ctrl_read;
    s_axi_arvalid && s_axi_arready && is_mapped(s_axi_araddr) &&
      reg_index(s_axi_araddr) == CTRL_IDX;
  endsequence

  a_reboot_resets: assert property (s_reboot_write |=> cpu_reset_out ##1 (cpu_reset_out &&
    !aux_ram_enable && !isp_mode && !exec_from_loader))
    else $error("soft reboot did not reset the control state");
  a_status_mode: assert property (s_ctrl_read |=> s_axi_rdata[7] == $past(forced_reg))
    else $error("control bit 7 does not show forced loader boot");
  a_reserved_zero: assert property (s_ctrl_read |=> s_axi_rdata[6:5] == 2'h0 &&
    s_axi_rdata[3:2] == 2'h0 && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("reserved control bits read non-zero");
  a_aux_write: assert property (wr_ok && wr_idx == CTRL_IDX && ulk_reg == ULK_OPEN
    |=> aux_ram_enable == $past(wr_byte[4]))
    else $error("aux RAM enable does not follow control bit 4");
  a_locked_ctrl: assert property (wr_ok && wr_idx == CTRL_IDX && ulk_reg != ULK_OPEN
    && !soft_rst_reg |=> $stable(aux_ram_enable) && $stable(loader_in_small_bank))
    else $error("control write taken while locked");
  a_isp_entry: assert property (enter_isp |=> isp_mode && exec_from_loader)
    else $error("programming mode not entered on idle wake");
  a_no_prog: assert property (!pe_reg |-> !flash_op_grant ##1 !flash_op_grant || pe_reg)
    else $error("flash operation granted with programming disabled");
  a_strap_catch: assert property ($rose(captured_reg) |-> forced_reg ==
    ((!$past(strap_s2_reg[2]) && !$past(strap_s2_reg[1])) || !$past(strap_s2_reg[0])))
    else $error("forced loader boot does not match straps");
  a_default_app: assert property (captured_reg && !forced_reg && !isp_mode |->
    !exec_from_loader)
    else $error("boot left the application bank without cause");
  a_sec_oneway: assert property (!chip_erase_req |=> (sec_reg & ~$past(sec_reg)) == 8'h00)
    else $error("security bit rose without erase");
  a_sec_hidden: assert property (isp_mode && s_axi_arvalid && s_axi_arready &&
    is_mapped(s_axi_araddr) && reg_index(s_axi_araddr) == SEC_IDX |=> s_axi_rdata == 32'h0)
    else $error("security register visible in programming mode");
  a_code_read_block: assert property (code_read_target_internal &&
    !code_read_from_internal && !sec_reg[SEC_CODE_READ_BIT] |-> !code_read_use_internal)
    else $error("external code read reached internal flash");
  a_p0_encode: assert property (!sec_reg[SEC_ENC_BIT] |=>
    p0_data_out == encode($past(p0_data_in)))
    else $error("port 0 data not encoded");
  a_pc_clear: assert property ($rose(isp_mode) && !forced_reg |-> pc_clear)
    else $error("program counter not cleared on bank switch");

endmodule

// File: tb/tb_isp_boot_security_control.sv
// Self-checking bench for the boot, reprogramming and code protection block.
`timescale 1ns/100ps
module tb_isp_boot_security_control
  import ibsc_pkg::*;
;
  // Key handed to the design, so the expected encoding is worked out here.
  localparam logic [7:0] TB_KEY = 8'h5A;
  localparam logic [9:0] CTRL_A = {CTRL_IDX, 2'b00};
  localparam logic [9:0] UNLK_A = {UNLOCK_IDX, 2'b00};
  localparam logic [9:0] STAT_A = {STATUS_IDX, 2'b00};
  localparam logic [9:0] SEC_A = {SEC_IDX, 2'b00};
  localparam int LIMIT = 20000;

  logic ref_clk, arst_n;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic strap_p27, strap_p26, strap_p43, cpu_idle, wake_irq, chip_erase_req, flash_op_req;
  logic code_read_from_internal, code_read_target_internal, cpu_reset_out, pc_clear;
  logic exec_from_loader, isp_mode, flash_op_grant, loader_in_small_bank, reprog_target_large;
  logic aux_ram_enable, code_read_use_internal, osc_half_gain;
  logic [7:0] p0_data_in, p0_data_out;
  logic [31:0] rdat;
  logic [1:0] resp;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  ibsc_isp_boot_security #(.ENC_KEY(TB_KEY)) ibsc_isp_boot_security_inst (
    .ref_clk(ref_clk), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .strap_p27(strap_p27), .strap_p26(strap_p26), .strap_p43(strap_p43),
    .cpu_idle(cpu_idle), .wake_irq(wake_irq), .chip_erase_req(chip_erase_req),
    .flash_op_req(flash_op_req), .code_read_from_internal(code_read_from_internal),
    .code_read_target_internal(code_read_target_internal), .p0_data_in(p0_data_in),
    .cpu_reset_out(cpu_reset_out), .pc_clear(pc_clear), .exec_from_loader(exec_from_loader),
    .isp_mode(isp_mode), .flash_op_grant(flash_op_grant),
    .loader_in_small_bank(loader_in_small_bank), .reprog_target_large(reprog_target_large),
    .aux_ram_enable(aux_ram_enable), .code_read_use_internal(code_read_use_internal),
    .p0_data_out(p0_data_out), .osc_half_gain(osc_half_gain)
  );

  // Free-running core clock at 100 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Watchdog; a hung handshake would otherwise stall the run for good.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask

  // Write master: each channel drops its valid at the edge its ready is seen.
  task automatic wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_p, w_p, b_p;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    while (b_p)
    begin
      @(posedge ref_clk);
      aw_p = aw_p && (s_axi_awready !== 1'b1);
      s_axi_awvalid <= aw_p;
      w_p = w_p && (s_axi_wready !== 1'b1);
      s_axi_wvalid <= w_p;
      if (s_axi_bvalid === 1'b1)
      begin
        r = s_axi_bresp;
        b_p = 1'b0;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_p, r_p;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ar_p = 1'b1;
    r_p = 1'b1;
    while (r_p)
    begin
      @(posedge ref_clk);
      ar_p = ar_p && (s_axi_arready !== 1'b1);
      s_axi_arvalid <= ar_p;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        r_p = 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string msg);
    rd(a, rdat, resp);
    check(rdat, exp, msg);
  endtask

  task automatic unlock();
    wr(UNLK_A, UNLOCK_KEY1, resp);
    wr(UNLK_A, UNLOCK_KEY2, resp);
  endtask

  // Four of the eight strap patterns are each caught at a fresh reset and shown in three places.
  task automatic t_straps();
    logic [2:0] pins [4] = '{3'b111, 3'b100, 3'b011, 3'b101};
    logic f [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      {strap_p43, strap_p27, strap_p26} <= pins[i];
      do_reset();
      check(exec_from_loader, f[i], "loader exec");
      rd_chk(CTRL_A, {24'h00_0000, f[i], 7'h00}, "forced flag");
      rd_chk(STAT_A, {28'h000_0000, 3'b100, f[i]}, "status forced");
    end
    // Straps return to their idle high level so no later reset boots the loader.
    {strap_p43, strap_p27, strap_p26} <= 3'b111;
    do_reset();
  endtask

  task automatic t_control();
    wr(CTRL_A, 8'h12, resp);
    rd_chk(CTRL_A, 32'h0000_0000, "locked write");
    unlock();
    rd_chk(STAT_A, 32'h0000_000C, "unlock open");
    wr(CTRL_A, 8'h12, resp);
    rd_chk(CTRL_A, 32'h0000_0012, "control read");
    check(aux_ram_enable, 1'b1, "aux on");
    check({loader_in_small_bank, reprog_target_large}, 2'b11, "bank select on");
    wr(CTRL_A, 8'h00, resp);
    check(aux_ram_enable, 1'b0, "aux off");
    check({loader_in_small_bank, reprog_target_large}, 2'b00, "bank select off");
    wr(UNLK_A, 8'h00, resp);
    wr(CTRL_A, 8'h10, resp);
    rd_chk(CTRL_A, 32'h0000_0000, "closed write");
  endtask

  // Idle plus wake enters programming only while program enable is set.
  task automatic t_isp();
    unlock();
    wr(CTRL_A, 8'h01, resp);
    flash_op_req <= 1'b1;
    cpu_idle <= 1'b1;
    @(posedge ref_clk);
    wake_irq <= 1'b1;
    @(posedge ref_clk);
    wake_irq <= 1'b0;
    #1 check({isp_mode, pc_clear, flash_op_grant}, 3'b111, "isp entry");
    @(posedge ref_clk);
    cpu_idle <= 1'b0;
    #1 check({pc_clear, flash_op_grant}, 2'b00, "pulse end, busy cpu");
    rd_chk(SEC_A, 32'h0000_0000, "security hidden");
    wr(CTRL_A, 8'h00, resp);
    cpu_idle <= 1'b1;
    wake_irq <= 1'b1;
    @(posedge ref_clk);
    wake_irq <= 1'b0;
    @(posedge ref_clk);
    #1 check({isp_mode, flash_op_grant}, 2'b00, "program disabled");
    @(posedge ref_clk);
    cpu_idle <= 1'b0;
    flash_op_req <= 1'b0;
  endtask

  task automatic t_reboot();
    unlock();
    wr(CTRL_A, 8'h93, resp);
    check(cpu_reset_out, 1'b1, "reboot held");
    repeat (10) @(posedge ref_clk);
    check(cpu_reset_out, 1'b0, "reboot done");
    rd_chk(CTRL_A, 32'h0000_0000, "reboot control");
    rd_chk(STAT_A, 32'h0000_0008, "reboot status");
  endtask

  task automatic code_read_sweep(input logic m);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      {code_read_from_internal, code_read_target_internal} <= i[1:0];
      #1 check(code_read_use_internal, i[0] & (i[1] | m), "code read route");
    end
  endtask

  // Security bits only fall; a chip erase brings them all back.
  task automatic t_security();
    logic [7:0] d;
    d = 8'hC3;
    p0_data_in <= d;
    code_read_sweep(1'b1);
    check(p0_data_out, d, "plain port");
    wr(SEC_A, 8'hF9, resp);
    rd_chk(SEC_A, 32'h0000_00F9, "sec program");
    wr(SEC_A, 8'hFF, resp);
    rd_chk(SEC_A, 32'h0000_00F9, "sec no rise");
    code_read_sweep(1'b0);
    check(p0_data_out, {d[2:0], d[7:3]} ^ TB_KEY, "encoded port");
    check(osc_half_gain, 1'b0, "full gain");
    wr(SEC_A, 8'h7F, resp);
    check(osc_half_gain, 1'b1, "half gain");
    @(posedge ref_clk);
    chip_erase_req <= 1'b1;
    @(posedge ref_clk);
    chip_erase_req <= 1'b0;
    rd_chk(SEC_A, 32'h0000_00FF, "erased");
    check({osc_half_gain, p0_data_out}, {1'b0, d}, "erase effects");
  endtask

  task automatic t_unmapped();
    wr(10'h310, 8'h00, resp);
    check(resp, RESP_SLVERR, "unmapped write");
    rd(10'h310, rdat, resp);
    check({rdat, resp}, {32'h0000_0000, RESP_SLVERR}, "unmapped read");
  endtask

  // Inputs get values at time zero, then the scenarios run in turn.
  initial
  begin
    arst_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {strap_p27, strap_p26, strap_p43} = 3'b111;
    {cpu_idle, wake_irq, chip_erase_req, flash_op_req} = 4'h0;
    {code_read_from_internal, code_read_target_internal} = 2'b00;
    p0_data_in = 8'h00;
    t_straps();
    t_control();
    t_isp();
    t_reboot();
    t_security();
    t_unmapped();
    close_out();
  end
endmodule
